// >>> core/dual_adc_ctrl.v
// Purpose: Control and output logic of a dual-channel 14-bit converter.
// Assumes: I_REF_CLK is the input clock; converter core results are synchronous.
// Notes:   Overview of operation follows; register space is byte wide.
`timescale 1ns/1ps
`include "dual_adc_consts.vh"

module dual_adc_ctrl #(
  parameter W        = `CODE_W,      // Code width.
  parameter LAT      = `LATENCY,     // Pipeline latency in sample cycles.
  parameter CLK_MHZ  = `CLK_MHZ,     // Input clock rate.
  parameter RELOCK   = `RELOCK_CYC   // Relock wait in input clock cycles.
) (
  input  wire         I_REF_CLK,       // Input clock.
  input  wire         I_RST_N,         // Synchronous reset, active low.
  input  wire [8:0]   I_ADDR,          // Register address.
  input  wire [7:0]   I_WDATA,         // Register write data.
  input  wire         I_WR,            // Write strobe.
  input  wire         I_RD,            // Read strobe.
  output reg  [7:0]   O_RDATA,         // Read data, one cycle after strobe.
  input  wire         I_ALIGN,         // External alignment input.
  input  wire         I_POWER_DOWN_PIN,// Power-down pin, high requests power-down.
  input  wire         I_OUTPUT_DISABLE,// Output-disable pin, high floats outputs.
  input  wire         I_PIN_MODE,      // High: format from strap pins.
  input  wire         I_FORMAT_STRAP,  // Format strap pin, high for twos complement.
  input  wire         I_STAB_STRAP,    // Stabilizer strap pin, high enables.
  input  wire [W-1:0] I_RAW_A,         // Channel A raw offset-binary code.
  input  wire         I_OVR_HI_A,      // Channel A above full scale.
  input  wire         I_OVR_LO_A,      // Channel A below full scale.
  input  wire [W-1:0] I_RAW_B,         // Channel B raw offset-binary code.
  input  wire         I_OVR_HI_B,      // Channel B above full scale.
  input  wire         I_OVR_LO_B,      // Channel B below full scale.
  output reg  [W-1:0] O_DATA_A,        // Channel A output data.
  output reg  [W-1:0] O_DATA_B,        // Channel B output data.
  output reg          O_OVR_A,         // Channel A over-range flag.
  output reg          O_OVR_B,         // Channel B over-range flag.
  output reg          O_DATA_A_OE,     // Channel A data drivers enabled.
  output reg          O_DATA_B_OE,     // Channel B data drivers enabled.
  output reg          O_DCO_A,         // Channel A data clock output.
  output reg          O_DCO_B,         // Channel B data clock output.
  output reg          O_DCO_A_OE,      // Channel A data clock enabled.
  output reg          O_DCO_B_OE,      // Channel B data clock enabled.
  output reg          O_SAMPLE_CLK,    // Internal sample clock.
  output reg          O_SAMPLE_TICK,   // One-cycle pulse at each sampling edge.
  output reg          O_REF_ON,        // Reference circuitry powered.
  output reg          O_CORE_ON,       // Converter core powered.
  output reg          O_STAB_LOCKED    // Stabilizer active and settled.
);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  reg [1:0] pwr_mode;
  reg       stab_en;
  reg [2:0] div_sel;     // Ratio minus one.
  reg [7:0] out_ctrl;
  reg [7:0] dco_ctrl;
  reg [7:0] sync_ctrl;   // Bit 3 is the armed flag, set on write.
  reg       strap_fmt;
  reg       strap_stab;
  reg       strap_done;

  // Address decode shared by the write and the read path.
  function is_reg;
    input [8:0] a;
    input [8:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Alignment synchronizer
  // --------------------------------------------------------------------------
  reg  align_meta;
  reg  align_sync;
  reg  align_prev;
  wire align_edge = align_sync & ~align_prev;

  // The first stage feeds only the second; edge detection reads later stages.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      align_meta <= 1'b0;
      align_sync <= 1'b0;
      align_prev <= 1'b0;
    end else begin
      align_meta <= I_ALIGN;
      align_sync <= align_meta;
      align_prev <= align_sync;
    end
  end

  // Once-only mode needs the armed flag; every-pulse mode acts on each edge.
  wire align_hit = align_edge & sync_ctrl[`SYNC_EN_BIT] &
                   (~sync_ctrl[`SYNC_ONCE_BIT] | sync_ctrl[`SYNC_ARMED_BIT]);

  // --------------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------------
  wire pd_req  = I_POWER_DOWN_PIN | (pwr_mode == `PWR_DOWN);
  wire stby    = ~pd_req & (pwr_mode == `PWR_STANDBY);
  wire running = ~pd_req & ~stby;

  // --------------------------------------------------------------------------
  // Register writes and strap capture
  // --------------------------------------------------------------------------
  // Straps are caught at the first clock after reset release, not under reset.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      pwr_mode   <= `RST_POWER;
      stab_en    <= 1'b1;
      div_sel    <= `RST_DIV;
      out_ctrl   <= `RST_OUTPUT;
      dco_ctrl   <= `RST_DCO;
      sync_ctrl  <= `RST_SYNC;
      strap_fmt  <= 1'b0;
      strap_stab <= 1'b1;
      strap_done <= 1'b0;
    end else begin
      if (!strap_done) begin
        strap_fmt  <= I_FORMAT_STRAP;
        strap_stab <= I_STAB_STRAP;
        strap_done <= 1'b1;
      end
      // A used pulse disarms; a write in the same cycle rearms and wins.
      if (align_hit) begin
        sync_ctrl[`SYNC_ARMED_BIT] <= 1'b0;
      end
      if (I_WR) begin
        if (is_reg(I_ADDR, `REG_POWER)) begin
          pwr_mode <= I_WDATA[1:0];
        end
        if (is_reg(I_ADDR, `REG_CLOCK)) begin
          stab_en <= I_WDATA[0];
        end
        if (is_reg(I_ADDR, `REG_DIVIDER)) begin
          div_sel <= I_WDATA[2:0];
        end
        if (is_reg(I_ADDR, `REG_OUTPUT)) begin
          out_ctrl <= I_WDATA;
        end
        if (is_reg(I_ADDR, `REG_DCO)) begin
          dco_ctrl <= I_WDATA;
        end
        if (is_reg(I_ADDR, `REG_SYNC)) begin
          sync_ctrl <= {I_WDATA[7:4], 1'b1, I_WDATA[2:0]};
        end
      end
    end
  end

  // Strap mode overrides the register choices for format and stabilizer.
  wire [1:0] fmt_sel  = I_PIN_MODE ? (strap_fmt ? `FMT_TWOS : `FMT_OFFSET)
                                   : out_ctrl[1:0];
  wire       stab_sel = I_PIN_MODE ? strap_stab : stab_en;

  // --------------------------------------------------------------------------
  // Input clock divider
  // --------------------------------------------------------------------------
  // The loop is only run at sample rates of 20 MHz and up; below that it idles.
  // The rate is worked out at full width so a ratio of eight cannot wrap.
  wire [31:0] rate_min = ({29'h0, div_sel} + 32'h1) * `STAB_MIN_MHZ;
  wire        rate_ok  = (CLK_MHZ >= rate_min);
  wire        stab_ok  = stab_sel & rate_ok & running & (div_sel != 3'h0);
  wire [3:0]  ratio    = {1'b0, div_sel} + 4'h1;
  reg  [2:0]  div_cnt;
  wire [2:0]  half_pt  = ratio[3:1];
  wire        div_end  = (div_cnt == div_sel);

  // An accepted pulse returns the divider to count zero, its initial state.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      div_cnt       <= 3'h0;
      O_SAMPLE_TICK <= 1'b0;
      O_SAMPLE_CLK  <= 1'b0;
    end else begin
      if (align_hit || div_end || !running) begin
        div_cnt <= 3'h0;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
      O_SAMPLE_TICK <= running & (align_hit | div_end);
      // With the stabilizer the falling edge lands at half period, rounded down; without,
      // high lasts one input cycle, so odd ratios keep the raw duty cycle.
      if (!running) begin
        O_SAMPLE_CLK <= 1'b0;
      end else if (align_hit || div_end) begin
        O_SAMPLE_CLK <= 1'b1;
      end else if (stab_ok && (div_cnt + 3'h1 == half_pt)) begin
        O_SAMPLE_CLK <= 1'b0;
      end else if (!stab_ok) begin
        O_SAMPLE_CLK <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Stabilizer lock
  // --------------------------------------------------------------------------
  // Lock is only reported while the stabilizer really retimes the clock.
  reg  [15:0] lock_cnt;
  reg  [2:0]  div_seen;

  // A ratio change restarts the relock wait before locked is reported again.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      lock_cnt      <= 16'h0000;
      div_seen      <= `RST_DIV;
      O_STAB_LOCKED <= 1'b0;
    end else begin
      div_seen <= div_sel;
      if (!stab_ok || div_seen != div_sel) begin
        lock_cnt      <= 16'h0000;
        O_STAB_LOCKED <= 1'b0;
      end else if ({16'h0000, lock_cnt} == RELOCK) begin
        O_STAB_LOCKED <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Format and pipeline, one lane per channel
  // --------------------------------------------------------------------------
  wire [W-1:0] raw  [0:1];
  wire [1:0]   hi;
  wire [1:0]   lo;
  wire [W:0]   lane_out [0:1];

  assign raw[0] = I_RAW_A;
  assign raw[1] = I_RAW_B;
  assign hi     = {I_OVR_HI_B, I_OVR_HI_A};
  assign lo     = {I_OVR_LO_B, I_OVR_LO_A};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_lane
      wire [W-1:0] code;
      wire         over;
      reg  [W:0]   pipe [0:LAT];
      integer      k;

      adc_code_format #(.W(W)) u_fmt (
        .i_raw     (raw[ch]),
        .i_over_hi (hi[ch]),
        .i_over_lo (lo[ch]),
        .i_fmt     (fmt_sel),
        .o_code    (code),
        .o_over    (over)
      );

      // Stage zero takes the sample; stage LAT holds it nine ticks later.
      always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
          for (k = 0; k <= LAT; k = k + 1) begin
            pipe[k] <= {(W+1){1'b0}};
          end
        end else if (O_SAMPLE_TICK) begin
          pipe[0] <= {over, code};
          for (k = 1; k <= LAT; k = k + 1) begin
            pipe[k] <= pipe[k-1];
          end
        end
      end
      assign lane_out[ch] = pipe[LAT];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------------------
  // Multiplexed mode puts A on bus A while the sample clock is high and B
  // while it is low; bus B keeps its own lane so no data is lost.
  wire mux_on  = out_ctrl[`OUT_MUX_BIT];
  wire dco_inv = dco_ctrl[`DCO_INV_BIT];
  wire drive   = ~pd_req & ~stby & ~I_OUTPUT_DISABLE;
  wire [W:0] bus_a = (mux_on && !O_SAMPLE_CLK) ? lane_out[1] : lane_out[0];

  // Outputs are registered; the pin-level enable is not a fast bus switch.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_DATA_A    <= {W{1'b0}};
      O_DATA_B    <= {W{1'b0}};
      O_OVR_A     <= 1'b0;
      O_OVR_B     <= 1'b0;
      O_DATA_A_OE <= 1'b0;
      O_DATA_B_OE <= 1'b0;
      O_DCO_A     <= 1'b0;
      O_DCO_B     <= 1'b0;
      O_DCO_A_OE  <= 1'b0;
      O_DCO_B_OE  <= 1'b0;
      O_REF_ON    <= 1'b0;
      O_CORE_ON   <= 1'b0;
    end else begin
      O_DATA_A    <= bus_a[W-1:0];
      O_OVR_A     <= bus_a[W];
      O_DATA_B    <= lane_out[1][W-1:0];
      O_OVR_B     <= lane_out[1][W];
      O_DCO_A     <= O_SAMPLE_CLK ^ dco_inv;
      O_DCO_B     <= O_SAMPLE_CLK ^ dco_inv;
      O_DATA_A_OE <= drive & ~out_ctrl[`OUT_DIS_A_BIT];
      O_DCO_A_OE  <= drive & ~out_ctrl[`OUT_DIS_A_BIT];
      O_DATA_B_OE <= drive & ~out_ctrl[`OUT_DIS_B_BIT];
      O_DCO_B_OE  <= drive & ~out_ctrl[`OUT_DIS_B_BIT];
      O_REF_ON    <= ~pd_req;
      O_CORE_ON   <= running;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Unmapped addresses and idle cycles read as zero.
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (!I_RD) begin
      O_RDATA <= 8'h00;
    end else if (is_reg(I_ADDR, `REG_STATUS)) begin
      O_RDATA <= {2'h0, div_cnt, O_STAB_LOCKED, stby, pd_req};
    end else if (is_reg(I_ADDR, `REG_POWER)) begin
      O_RDATA <= {6'h00, pwr_mode};
    end else if (is_reg(I_ADDR, `REG_CLOCK)) begin
      O_RDATA <= {7'h00, stab_en};
    end else if (is_reg(I_ADDR, `REG_DIVIDER)) begin
      O_RDATA <= {5'h00, div_sel};
    end else if (is_reg(I_ADDR, `REG_OUTPUT)) begin
      O_RDATA <= out_ctrl;
    end else if (is_reg(I_ADDR, `REG_DCO)) begin
      O_RDATA <= dco_ctrl;
    end else if (is_reg(I_ADDR, `REG_SYNC)) begin
      O_RDATA <= sync_ctrl;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule // dual_adc_ctrl

// >>> core/dual_adc_consts.vh
// Purpose: Shared constants of the dual converter control and output block.
// Assumes: Byte-wide control registers reached over a plain address port.
// Notes:   Offsets are byte addresses of the control space.
`ifndef DUAL_ADC_CONSTS_VH
`define DUAL_ADC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_STATUS      9'h002
`define REG_POWER       9'h008
`define REG_CLOCK       9'h009
`define REG_DIVIDER     9'h00B
`define REG_OUTPUT      9'h014
`define REG_DCO         9'h016
`define REG_SYNC        9'h100

// ----------------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------------
`define PWR_NORMAL      2'h0
`define PWR_DOWN        2'h1
`define PWR_STANDBY     2'h2
`define FMT_OFFSET      2'h0
`define FMT_TWOS        2'h1
`define FMT_GRAY        2'h2
`define OUT_DIS_A_BIT   4
`define OUT_DIS_B_BIT   5
`define OUT_MUX_BIT     6
`define DCO_INV_BIT     7
`define SYNC_EN_BIT     1
`define SYNC_ONCE_BIT   2
`define SYNC_ARMED_BIT  3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_POWER       2'h0
`define RST_DIV         3'h0
`define RST_OUTPUT      8'h00
`define RST_DCO         8'h00
`define RST_SYNC        8'h00

// ----------------------------------------------------------------------------
// Codes and timing
// ----------------------------------------------------------------------------
`define CODE_W          14
`define CODE_MIN        14'h0000
`define CODE_MAX        14'h3FFF
`define LATENCY         9
`define CLK_MHZ         20
`define STAB_MIN_MHZ    20
`define RELOCK_NS       1500
`define RELOCK_CYC      ((`RELOCK_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> core/adc_code_format.v
// Purpose: Clamps one raw conversion and casts it into the chosen code format.
// Assumes: Raw code is offset binary; over-range inputs are levels.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "dual_adc_consts.vh"

module adc_code_format #(
  parameter W = `CODE_W
) (
  input  wire [W-1:0] i_raw,      // Raw offset-binary code.
  input  wire         i_over_hi,  // Input above positive full scale.
  input  wire         i_over_lo,  // Input below negative full scale.
  input  wire [1:0]   i_fmt,      // Selected output format.
  output reg  [W-1:0] o_code,     // Formatted code.
  output wire         o_over      // Over-range flag.
);

  // --------------------------------------------------------------------------
  // Gray conversion
  // --------------------------------------------------------------------------
  // Top bit kept; each lower bit xors with the next higher binary bit.
  function [W-1:0] to_gray;
    input [W-1:0] b;
    begin
      to_gray = b ^ (b >> 1);
    end
  endfunction

  reg [W-1:0] clamped;

  // Outside full scale the code pins at the matching end and the flag rises.
  assign o_over = i_over_hi | i_over_lo;

  // Clamp first so every format sees the same limit value.
  always @* begin
    clamped = i_raw;
    if (i_over_hi) begin
      clamped = {W{1'b1}};
    end else if (i_over_lo) begin
      clamped = {W{1'b0}};
    end
    case (i_fmt)
      `FMT_TWOS: o_code = {~clamped[W-1], clamped[W-2:0]};
      `FMT_GRAY: o_code = to_gray(clamped);
      default:   o_code = clamped;
    endcase
  end

endmodule // adc_code_format

// >>> sim/dual_adc_ctrl_sva.sv
// Purpose: Port-level checks on the dual converter control block.
// Assumes: One input clock domain with a synchronous active-low reset.
// Notes:   Tick counters keep the over-range bounds valid at every divide ratio.
`timescale 1ns/1ps
`include "dual_adc_consts.vh"
module dual_adc_ctrl_sva #(
  parameter CLK_MHZ = 20                                                // Input clock rate.
) (
  input wire logic I_REF_CLK, I_RST_N,                                  // Clock and reset.
  input wire logic I_POWER_DOWN_PIN, I_OUTPUT_DISABLE,                  // Power and float pins.
  input wire logic I_WR,                                                // Write strobe.
  input wire logic [8:0] I_ADDR,                                        // Register address.
  input wire logic I_OVR_HI_A, I_OVR_LO_A, I_OVR_HI_B, I_OVR_LO_B,      // Range inputs.
  input wire logic O_OVR_A, O_OVR_B, O_SAMPLE_CLK, O_SAMPLE_TICK,       // Flags and sample timing.
  input wire logic O_DATA_A_OE, O_DATA_B_OE, O_DCO_A_OE, O_DCO_B_OE,    // Driver enables.
  input wire logic O_DCO_A, O_DCO_B, O_REF_ON, O_CORE_ON, O_STAB_LOCKED // Clocks and power.
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  // The over-range counters count ticks, not cycles, so the pipeline bound holds at any ratio; gap counts cycles.
  logic [3:0] n_ovr, n_clr, gap;
  wire        any_a = I_OVR_HI_A | I_OVR_LO_A;
  wire        any_b = I_OVR_HI_B | I_OVR_LO_B;
  always @(posedge I_REF_CLK) begin
    if (!I_RST_N || !(any_a && any_b)) n_ovr <= 4'h0;
    else if (O_SAMPLE_TICK && n_ovr != 4'hF) n_ovr <= n_ovr + 4'h1;
    if (!I_RST_N || any_a || any_b) n_clr <= 4'h0;
    else if (O_SAMPLE_TICK && n_clr != 4'hF) n_clr <= n_clr + 4'h1;
    if (!I_RST_N || !O_CORE_ON || O_SAMPLE_TICK) gap <= 4'h0;
    else if (gap != 4'hF) gap <= gap + 4'h1;
  end
  AST_PD_PIN: assert property (I_POWER_DOWN_PIN [*4] |-> !(O_DATA_A_OE | O_DATA_B_OE | O_CORE_ON | O_REF_ON))
    else $error("power-down pin left drivers or core on");
  AST_OE_PIN: assert property ($rose(I_OUTPUT_DISABLE) ##1 I_OUTPUT_DISABLE [*3] |->
    !(O_DATA_A_OE | O_DATA_B_OE | O_DCO_A_OE | O_DCO_B_OE))
    else $error("output-disable pin left a driver on");
  AST_OE_PAIR: assert property (O_DATA_A_OE == O_DCO_A_OE && O_DATA_B_OE == O_DCO_B_OE)
    else $error("data and data clock enables differ");
  AST_OVR_SET: assert property (n_ovr > 4'hA |-> O_OVR_A && O_OVR_B)
    else $error("over-range flag missing");
  AST_OVR_CLR: assert property (n_clr > 4'hA |-> !O_OVR_A && !O_OVR_B)
    else $error("over-range flag without cause");
  AST_GAP: assert property (gap < 4'h8)
    else $error("sample ticks more than eight cycles apart");
  AST_REF: assert property (O_CORE_ON |-> O_REF_ON)
    else $error("core on with reference off");
  // A polarity write flips the data clock by itself, so that one cycle is left out.
  AST_DCO: assert property ($changed(O_SAMPLE_CLK) && !($past(I_WR) && $past(I_ADDR) == `REG_DCO) |=>
    $changed(O_DCO_A) && O_DCO_A == O_DCO_B)
    else $error("data clock does not follow sample clock");
  AST_STAB: assert property (CLK_MHZ < 40 |-> !O_STAB_LOCKED)
    else $error("stabilizer active below its rate");
  CV_OVR: cover property (n_ovr > 4'hA);
  CV_GAP: cover property (gap == 4'h7);
  CV_STBY: cover property (O_REF_ON && !O_CORE_ON);
endmodule // dual_adc_ctrl_sva

bind dual_adc_ctrl dual_adc_ctrl_sva #(.CLK_MHZ(CLK_MHZ)) u_sva (.I_REF_CLK, .I_RST_N, .I_POWER_DOWN_PIN,
  .I_WR, .I_ADDR,
  .I_OUTPUT_DISABLE, .I_OVR_HI_A, .I_OVR_LO_A, .I_OVR_HI_B, .I_OVR_LO_B, .O_OVR_A, .O_OVR_B,
  .O_SAMPLE_CLK, .O_SAMPLE_TICK, .O_DATA_A_OE, .O_DATA_B_OE, .O_DCO_A_OE, .O_DCO_B_OE,
  .O_DCO_A, .O_DCO_B, .O_REF_ON, .O_CORE_ON, .O_STAB_LOCKED);

// >>> sim/dclk_capture.sv
// Purpose: Board capture register fed by one data clock and data bus.
// Assumes: The edge select mirrors the polarity set in the converter.
// Notes:   Behavioural; it sees the resolved bus, not the driver.
`timescale 1ns/1ps
module dclk_capture (
  input  wire logic        i_dco,  // Data clock from the converter.
  input  wire logic        i_inv,  // High: capture on the falling edge.
  input  wire logic [13:0] i_bus,  // Resolved data bus.
  output logic      [13:0] o_word  // Last captured word.
);
  // Capture only on the selected edge, as a real register would.
  always @(posedge i_dco or negedge i_dco) begin
    if (i_dco ^ i_inv) o_word <= i_bus;
  end
endmodule // dclk_capture

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the dual converter control block.
// Assumes: 20 MHz input clock; read data one cycle after the strobe.
// Notes:   Expected codes are worked out here from the raw stimulus.
`timescale 1ns/1ps
`include "dual_adc_consts.vh"
module testbench;
  reg         clk = 0, rst_n = 0, wr = 0, rd = 0, align = 0, pd = 0, oed = 0, inv = 0;
  reg         pmode = 0, fstrap = 0, sstrap = 1, ohi_a = 0, olo_a = 0, ohi_b = 0, olo_b = 0;
  reg  [8:0]  addr = 9'h000;
  reg  [7:0]  wdata = 8'h00;
  reg  [13:0] raw_a = 14'h0000, raw_b = 14'h0000;
  wire [7:0]  rdata;
  wire [13:0] da, db, cap;
  wire        ova, ovb, aoe, boe, dcoa, dcob, caoe, cboe, sclk, tick, refon, coreon, lock;
  integer     mismatches = 0, n_checks = 0, cyc = 0;
  // A released bus shows the inverse, never the last driven code.
  wire [13:0] bus_a = aoe ? da : ~da;

  dual_adc_ctrl #(.RELOCK(4)) u_dual_adc_ctrl (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ALIGN(align), .I_POWER_DOWN_PIN(pd),
    .I_OUTPUT_DISABLE(oed), .I_PIN_MODE(pmode), .I_FORMAT_STRAP(fstrap), .I_STAB_STRAP(sstrap),
    .I_RAW_A(raw_a), .I_OVR_HI_A(ohi_a), .I_OVR_LO_A(olo_a), .I_RAW_B(raw_b), .I_OVR_HI_B(ohi_b),
    .I_OVR_LO_B(olo_b), .O_DATA_A(da), .O_DATA_B(db), .O_OVR_A(ova), .O_OVR_B(ovb),
    .O_DATA_A_OE(aoe), .O_DATA_B_OE(boe), .O_DCO_A(dcoa), .O_DCO_B(dcob), .O_DCO_A_OE(caoe),
    .O_DCO_B_OE(cboe), .O_SAMPLE_CLK(sclk), .O_SAMPLE_TICK(tick), .O_REF_ON(refon),
    .O_CORE_ON(coreon), .O_STAB_LOCKED(lock));
  dclk_capture u_dclk_capture (.i_dco(dcoa), .i_inv(inv), .i_bus(bus_a), .o_word(cap));

  always #25 clk = ~clk;
  // The whole run needs some 370 cycles; a hang is cut short here.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected %0s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rst;
    @(posedge clk) rst_n <= 0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    wt(1);
  endtask
  task wrt(input [8:0] a, input [7:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
  endtask
  task rdc(input [8:0] a, input [7:0] exp);
    @(posedge clk) addr <= a;
    rd <= 1;
    @(posedge clk) rd <= 0;
    #1 chk("rdata", rdata, exp);
  endtask
  function [13:0] fmt(input integer f, input [13:0] r);
    fmt = f == 1 ? r ^ 14'h2000 : f == 2 ? r ^ (r >> 1) : r;
  endfunction
  task pulse(input exp);
    @(posedge clk) align <= 1;
    repeat (3) @(posedge clk);
    #1 chk("align_tick", tick, exp);
    @(posedge clk) align <= 0;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_regs;
    rdc(`REG_CLOCK, 8'h01);
    rdc(`REG_DIVIDER, 8'h00);
    wrt(9'h1FF, 8'hFF);
    rdc(9'h1FF, 8'h00);
  endtask
  task t_lat;
    integer n;
    @(posedge clk) raw_a <= 14'h1234;
    n = 0;
    while (da !== 14'h1234 && n < 40) begin
      wt(1);
      n = n + 1;
    end
    chk("latency", n, 11);
    chk("locked", lock, 0);
  endtask
  task t_fmt;
    integer f;
    @(posedge clk) raw_a <= 14'h2A5C;
    raw_b <= 14'h0F31;
    for (f = 0; f < 3; f = f + 1) begin
      wrt(`REG_OUTPUT, f[7:0]);
      wt(14);
      chk("data_a", da, fmt(f, 14'h2A5C));
      chk("data_b", db, fmt(f, 14'h0F31));
    end
    chk("enables", {aoe, boe, caoe, cboe}, 4'hF);
  endtask
  task t_ovr;
    wrt(`REG_OUTPUT, 8'h01);
    @(posedge clk) ohi_a <= 1;
    olo_b <= 1;
    wt(14);
    chk("ovr", {ova, ovb, da, db}, {2'b11, 14'h1FFF, 14'h2000});
    @(posedge clk) ohi_a <= 0;
    olo_b <= 0;
    wt(14);
    chk("ovr_clear", {ova, ovb}, 2'b00);
  endtask
  task t_pwr;
    @(posedge clk) pd <= 1;
    wt(4);
    chk("pd_pin", {aoe, boe, caoe, cboe, coreon, refon}, 6'h00);
    @(posedge clk) pd <= 0;
    wt(14);
    chk("wake", {aoe, boe, caoe, cboe, coreon, refon}, 6'h3F);
    wrt(`REG_POWER, 8'h02);
    wt(4);
    chk("standby", {aoe, coreon, refon}, 3'b001);
    wrt(`REG_POWER, 8'h01);
    wt(4);
    chk("pd_reg", {aoe, coreon, refon}, 3'b000);
    wrt(`REG_POWER, 8'h00);
    wt(14);
  endtask
  task t_oe;
    @(posedge clk) oed <= 1;
    wt(4);
    chk("oe_pin", {aoe, boe, caoe, cboe}, 4'h0);
    @(posedge clk) oed <= 0;
    wrt(`REG_OUTPUT, 8'h10);
    wt(4);
    chk("dis_a", {aoe, boe, caoe, cboe}, 4'b0101);
    wrt(`REG_OUTPUT, 8'h20);
    wt(4);
    chk("dis_b", {aoe, boe, caoe, cboe}, 4'b1010);
  endtask
  task t_mux;
    reg sa, sb;
    sa = 0;
    sb = 0;
    wrt(`REG_DIVIDER, 8'h01);
    wrt(`REG_OUTPUT, 8'h40);
    wt(30);
    chk("locked_div2", lock, 0);
    repeat (4) begin
      wt(1);
      sa = sa | (da === 14'h2A5C);
      sb = sb | (da === 14'h0F31);
    end
    chk("mux", {sa, sb}, 2'b11);
    wrt(`REG_OUTPUT, 8'h00);
  endtask
  task t_dco;
    wt(30);
    chk("capture", cap, 14'h2A5C);
    @(posedge clk) inv <= 1;
    raw_a <= 14'h15A3;
    wrt(`REG_DCO, 8'h80);
    wt(30);
    chk("capture_inv", cap, 14'h15A3);
  endtask
  task t_align;
    integer n;
    wrt(`REG_DIVIDER, 8'h03);
    wrt(`REG_SYNC, 8'h02);
    pulse(1);
    pulse(1);
    wrt(`REG_SYNC, 8'h06);
    pulse(1);
    pulse(0);
    rdc(`REG_SYNC, 8'h06);
    wrt(`REG_DIVIDER, 8'h07);
    wt(1);
    while (tick !== 1'b1) wt(1);
    n = 0;
    do begin
      wt(1);
      n = n + 1;
    end while (tick !== 1'b1 && n < 20);
    chk("tick_gap", n, 8);
  endtask
  task t_strap;
    @(posedge clk) pmode <= 1;
    fstrap <= 1;
    rst;
    wt(14);
    chk("strap", da, 14'h35A3);
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst;
    t_regs;
    $display("regs end");
    t_lat;
    $display("latency end");
    t_fmt;
    $display("format end");
    t_ovr;
    $display("over-range end");
    t_pwr;
    $display("power end");
    t_oe;
    $display("enable end");
    t_mux;
    $display("mux end");
    t_dco;
    $display("data clock end");
    t_align;
    $display("align end");
    t_strap;
    $display("strap end");
    finish_test;
  end
endmodule // testbench
